// ==== hdl/can_tx_buffer_scheduler.sv ====
// Transmit buffer store, priority scheduler, abort handling and stamp timer.
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ns

// Function
// - Each buffer holds eight payload bytes; only length-code bytes are sent.
// - Four-bit length code counts bytes zero to eight in plain binary.
// - Remote frames send the programmed length code but no payload bytes.
// - Every buffer with empty flag clear joins selection just before frame start.
// - The pending buffer with smallest local priority value wins.
// - Equal smallest priorities resolve to the lowest buffer index.
// - With stamping on, timer value is stored into buffer after frame end.
// - Stamp timer free-runs on the bit clock; wraparound is not flagged.
// - Stamp timer is held at zero during initialization mode.
// - Stamp bytes are read-only; writes do nothing.
// - Three independent transmit buffers allow back-to-back queueing.
// - Each buffer has message bytes, one priority byte and two stamp bytes.
// - Selecting a buffer maps it into one shared foreground window.
// - After successful send the empty flag sets and a transmit request rises.
// - Selection repeats at every arbitration attempt, including error retries.
// - Abort is requested per buffer; a frame already started is not cancelled.
// - Granted abort sets empty flag and raises transmit request; acknowledge is set unless that buffer starts in the same cycle.
// - Remote request bit zero sends data frame, one sends remote frame.
module can_tx_buffer_scheduler #(
    parameter int NUM_BUF = 3
) (
    // Clock and reset.
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // Avalon-MM slave.
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    // Link engine side.
    input  wire logic        bus_idle_in,
    input  wire logic        tx_done_in,
    input  wire logic        tx_error_in,
    output logic             frame_start_out,
    output logic [1:0]       tx_buf_out,
    output logic             tx_remote_out,
    output logic [3:0]       tx_length_out,
    output logic [3:0]       tx_bytes_out,
    output logic             tx_irq_out,
    output logic             init_mode_out
);
    import txbuf_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SEND = 3'b010,
        ST_EOF  = 3'b100
    } tx_state_type;

    // Buffer storage: identifier, payload, length, priority, stamp per buffer.
    logic [7:0]  id_r       [NUM_BUF][ID_BYTES];
    logic [7:0]  id_nxt     [NUM_BUF][ID_BYTES];
    logic [7:0]  pay_r      [NUM_BUF][PAYLOAD_BYTES];
    logic [7:0]  pay_nxt    [NUM_BUF][PAYLOAD_BYTES];
    logic [7:0]  len_r      [NUM_BUF];
    logic [7:0]  len_nxt    [NUM_BUF];
    logic [7:0]  local_priority_field_r     [NUM_BUF];
    logic [7:0]  local_priority_field_nxt   [NUM_BUF];
    logic [15:0] stamp_r    [NUM_BUF];
    logic [15:0] stamp_nxt  [NUM_BUF];
    logic [2:0]  empty_r, empty_nxt;
    logic [2:0]  abreq_r, abreq_nxt;
    logic [2:0]  aback_r, aback_nxt;
    logic [2:0]  sel_r, sel_nxt;
    logic [7:0]  ctrl_r, ctrl_nxt;
    logic [15:0] timer_r, timer_nxt;
    logic [6:0]  tick_r, tick_nxt;
    tx_state_type state_r, state_nxt;
    logic [1:0]  active_r, active_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        wait_r, wait_nxt;
    logic        start_r, start_nxt;
    logic        irq_r, irq_nxt;
    logic        remote_r, remote_nxt;
    logic [3:0]  length_r, length_nxt;
    logic [3:0]  bytes_r, bytes_nxt;

    // Lowest selected index of a one-hot or multi-hot select value; 3 means none.
    function automatic logic [1:0] first_index(input logic [2:0] v);
        if (v[0]) begin
            return 2'd0;
        end else if (v[1]) begin
            return 2'd1;
        end else if (v[2]) begin
            return 2'd2;
        end
        return 2'd3;
    endfunction

    // Payload byte count from a length code: clamps codes above eight.
    function automatic logic [3:0] byte_count(input logic [3:0] frame_length_code, input logic remote);
        if (remote) begin
            return 4'h0;
        end else if (frame_length_code > 4'(DLC_MAX)) begin
            return 4'(DLC_MAX);
        end
        return frame_length_code;
    endfunction

    logic [1:0] fg_idx;
    logic [1:0] win_idx;
    logic [7:0] win_local_priority_field;
    logic       access_go;
    logic       fg_open;

    // Foreground window maps the lowest selected buffer.
    // Scheduler scans buffers in index order, keeping strict less-than, so ties keep the lower index.
    always_comb begin
        fg_idx    = first_index(sel_r);
        fg_open   = (fg_idx != 2'd3) && empty_r[fg_idx];
        access_go = wait_r && (avs_read_in || avs_write_in);
        win_idx   = 2'd3;
        win_local_priority_field  = 8'hFF;
        for (int b = 0; b < NUM_BUF; b++) begin
            if (!empty_r[b] && (win_idx == 2'd3 || local_priority_field_r[b] < win_local_priority_field)) begin
                win_idx  = 2'(b);
                win_local_priority_field = local_priority_field_r[b];
            end
        end
    end

    // Register window, flags and transmit sequencing share one next-state process,
    // since bus writes and link events both touch the empty and abort flags.
    always_comb begin
        logic [7:0] wb;
        logic [7:0] adr;
        wb         = avs_writedata_in[7:0];
        adr        = avs_address_in;
        id_nxt     = id_r;
        pay_nxt    = pay_r;
        len_nxt    = len_r;
        local_priority_field_nxt   = local_priority_field_r;
        stamp_nxt  = stamp_r;
        empty_nxt  = empty_r;
        abreq_nxt  = abreq_r;
        aback_nxt  = aback_r;
        sel_nxt    = sel_r;
        ctrl_nxt   = ctrl_r;
        state_nxt  = state_r;
        active_nxt = active_r;
        rdata_nxt  = 32'h0000_0000;
        wait_nxt   = 1'b1;
        start_nxt  = 1'b0;
        irq_nxt    = 1'b0;
        remote_nxt = remote_r;
        length_nxt = length_r;
        bytes_nxt  = bytes_r;
        // One wait cycle per access; the request is completed when waitrequest is low.
        if ((avs_read_in || avs_write_in) && wait_r) begin
            wait_nxt = 1'b0;
        end
        if (access_go && avs_read_in) begin
            if (adr < 8'h40) begin
                if (fg_open) begin
                    if (adr < 8'(OFS_PAYLOAD0)) begin
                        rdata_nxt = {24'h0, id_r[fg_idx][adr[3:2]]};
                    end else if (adr < 8'(OFS_LENGTH)) begin
                        rdata_nxt = {24'h0, pay_r[fg_idx][3'(adr[5:2] - 4'h4)]};
                    end else if (adr == 8'(OFS_LENGTH)) begin
                        rdata_nxt = {24'h0, len_r[fg_idx]};
                    end else if (adr == 8'(OFS_PRIORITY)) begin
                        rdata_nxt = {24'h0, local_priority_field_r[fg_idx]};
                    end else if (adr == 8'(OFS_STAMP_HI)) begin
                        rdata_nxt = {24'h0, stamp_r[fg_idx][15:8]};
                    end else if (adr == 8'(OFS_STAMP_LO)) begin
                        rdata_nxt = {24'h0, stamp_r[fg_idx][7:0]};
                    end
                end
            end else if (adr == OFS_TX_FLAG) begin
                rdata_nxt = {29'h0, empty_r};
            end else if (adr == OFS_ABORT_REQ) begin
                rdata_nxt = {29'h0, abreq_r};
            end else if (adr == OFS_ABORT_ACK) begin
                rdata_nxt = {29'h0, aback_r};
            end else if (adr == OFS_SELECT) begin
                rdata_nxt = {29'h0, sel_r};
            end else if (adr == OFS_CONTROL) begin
                rdata_nxt = {24'h0, ctrl_r};
            end
        end
        if (access_go && avs_write_in) begin
            if (adr < 8'h40) begin
                if (fg_open) begin
                    if (adr < 8'(OFS_PAYLOAD0)) begin
                        id_nxt[fg_idx][adr[3:2]] = wb;
                    end else if (adr < 8'(OFS_LENGTH)) begin
                        pay_nxt[fg_idx][3'(adr[5:2] - 4'h4)] = wb;
                    end else if (adr == 8'(OFS_LENGTH)) begin
                        len_nxt[fg_idx] = {4'h0, wb[3:0]};
                    end else if (adr == 8'(OFS_PRIORITY)) begin
                        local_priority_field_nxt[fg_idx] = wb;
                    end
                    // Stamp addresses fall through: no storage is written.
                end
            end else if (adr == OFS_TX_FLAG) begin
                empty_nxt = empty_r & ~wb[2:0];
            end else if (adr == OFS_ABORT_REQ) begin
                abreq_nxt = abreq_r | (wb[2:0] & ~empty_r);
            end else if (adr == OFS_SELECT) begin
                sel_nxt = wb[2:0] & empty_r; // Only empty buffers may be selected.
            end else if (adr == OFS_CONTROL) begin
                ctrl_nxt = {6'h0, wb[1:0]};
            end
        end
        // Transmit sequencer.
        case (state_r)
            ST_IDLE: begin
                for (int b = 0; b < NUM_BUF; b++) begin
                    // Pending abort on a buffer not in flight is granted here.
                    if (abreq_nxt[b] && !empty_nxt[b]) begin
                        aback_nxt[b] = 1'b1;
                        empty_nxt[b] = 1'b1;
                        abreq_nxt[b] = 1'b0;
                        irq_nxt      = 1'b1;
                    end
                end
                if (!ctrl_r[CTRL_INIT_BIT] && bus_idle_in && win_idx != 2'd3 && !abreq_nxt[win_idx]) begin
                    active_nxt           = win_idx;
                    aback_nxt[win_idx]   = 1'b0;
                    start_nxt            = 1'b1;
                    remote_nxt           = id_r[win_idx][1][RTR_BIT];
                    length_nxt           = len_r[win_idx][3:0];
                    bytes_nxt            = byte_count(len_r[win_idx][3:0], id_r[win_idx][1][RTR_BIT]);
                    state_nxt            = ST_SEND;
                end
            end
            ST_SEND: begin
                if (tx_error_in) begin
                    state_nxt = ST_IDLE; // Buffer stays pending and re-arbitrates.
                end else if (tx_done_in) begin
                    state_nxt = ST_EOF;
                end
            end
            ST_EOF: begin
                if (ctrl_r[CTRL_TIME_BIT]) begin
                    stamp_nxt[active_r] = timer_r;
                end
                empty_nxt[active_r] = 1'b1;
                abreq_nxt[active_r] = 1'b0;
                irq_nxt             = 1'b1;
                state_nxt           = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Stamp timer: bit-clock prescaler and free-running counter.
    always_comb begin
        tick_nxt  = (tick_r == 7'(BIT_CYCLES - 1)) ? 7'h00 : 7'(tick_r + 7'h01);
        timer_nxt = (tick_r == 7'(BIT_CYCLES - 1)) ? 16'(timer_r + 16'h0001) : timer_r;
        if (ctrl_r[CTRL_INIT_BIT]) begin
            tick_nxt  = 7'h00;
            timer_nxt = 16'h0000;
        end
    end

    // Registering of all state; message storage needs no reset, stamps clear so early reads are defined.
    always_ff @(posedge clk_in) begin
        id_r    <= id_nxt;
        pay_r   <= pay_nxt;
        len_r   <= len_nxt;
        local_priority_field_r  <= local_priority_field_nxt;
        if (sys_rst_in) begin
            stamp_r  <= '{default: 16'h0000};
            empty_r  <= EMPTY_RESET;
            abreq_r  <= 3'h0;
            aback_r  <= 3'h0;
            sel_r    <= 3'h0;
            ctrl_r   <= CONTROL_RESET;
            timer_r  <= 16'h0000;
            tick_r   <= 7'h00;
            state_r  <= ST_IDLE;
            active_r <= 2'd0;
            rdata_r  <= 32'h0000_0000;
            wait_r   <= 1'b1;
            start_r  <= 1'b0;
            irq_r    <= 1'b0;
            remote_r <= 1'b0;
            length_r <= 4'h0;
            bytes_r  <= 4'h0;
        end else begin
            stamp_r  <= stamp_nxt;
            empty_r  <= empty_nxt;
            abreq_r  <= abreq_nxt;
            aback_r  <= aback_nxt;
            sel_r    <= sel_nxt;
            ctrl_r   <= ctrl_nxt;
            timer_r  <= timer_nxt;
            tick_r   <= tick_nxt;
            state_r  <= state_nxt;
            active_r <= active_nxt;
            rdata_r  <= rdata_nxt;
            wait_r   <= wait_nxt;
            start_r  <= start_nxt;
            irq_r    <= irq_nxt;
            remote_r <= remote_nxt;
            length_r <= length_nxt;
            bytes_r  <= bytes_nxt;
        end
    end

    // Outputs straight from flip-flops.
    assign avs_readdata_out    = rdata_r;
    assign avs_waitrequest_out = wait_r;
    assign frame_start_out     = start_r;
    assign tx_buf_out          = active_r;
    assign tx_remote_out       = remote_r;
    assign tx_length_out       = length_r;
    assign tx_bytes_out        = bytes_r;
    assign tx_irq_out          = irq_r;
    assign init_mode_out       = ctrl_r[CTRL_INIT_BIT];

    // Assertions.
    property p_timer_init;
        @(posedge clk_in) disable iff (sys_rst_in) ctrl_r[CTRL_INIT_BIT] |=> timer_r == 16'h0000;
    endproperty
    a_timer_init: assert property (p_timer_init) else $error("Timer not zero in init mode.");

    property p_start_pending;
        @(posedge clk_in) disable iff (sys_rst_in) frame_start_out |-> !empty_r[tx_buf_out];
    endproperty
    a_start_pending: assert property (p_start_pending) else $error("Started an empty buffer.");

    property p_win_local_priority_field;
        @(posedge clk_in) disable iff (sys_rst_in)
            $rose(frame_start_out) |-> (empty_r[0] || local_priority_field_r[0] >= local_priority_field_r[tx_buf_out]);
    endproperty
    a_win_local_priority_field: assert property (p_win_local_priority_field) else $error("Higher-priority buffer was skipped.");

    property p_tie_low;
        @(posedge clk_in) disable iff (sys_rst_in)
            frame_start_out && tx_buf_out == 2'd1 |-> (empty_r[0] || local_priority_field_r[0] > local_priority_field_r[1]);
    endproperty
    a_tie_low: assert property (p_tie_low) else $error("Tie not resolved to lower index.");

    property p_remote_bytes;
        @(posedge clk_in) disable iff (sys_rst_in) frame_start_out && tx_remote_out |-> tx_bytes_out == 4'h0;
    endproperty
    a_remote_bytes: assert property (p_remote_bytes) else $error("Remote frame with payload.");

    sequence s_done;
        state_r == ST_SEND && tx_done_in && !tx_error_in;
    endsequence
    property p_done_empty;
        @(posedge clk_in) disable iff (sys_rst_in) s_done ##1 1'b1 |=> empty_r[$past(active_r)] && tx_irq_out;
    endproperty
    a_done_empty: assert property (p_done_empty) else $error("Sent buffer not released.");

    property p_abort_ack;
        @(posedge clk_in) disable iff (sys_rst_in) $rose(aback_r[2]) |-> empty_r[2] && tx_irq_out;
    endproperty
    a_abort_ack: assert property (p_abort_ack) else $error("Abort acknowledge without release.");

    property p_bytes_max;
        @(posedge clk_in) disable iff (sys_rst_in) frame_start_out |-> tx_bytes_out <= 4'h8;
    endproperty
    a_bytes_max: assert property (p_bytes_max) else $error("Byte count above eight.");
endmodule

// ==== inc/txbuf_pkg.sv ====
// Package holding register map, field layout and timing constants of the transmit buffer scheduler.
package txbuf_pkg;
    // Word offsets (byte addresses) of the register window.
    localparam logic [5:0] OFS_ID0       = 6'h00; // Identifier bytes 0..3 occupy words 0x00..0x0C.
    localparam logic [5:0] OFS_PAYLOAD0  = 6'h10; // Payload bytes occupy words 0x10..0x2C.
    localparam logic [5:0] OFS_LENGTH    = 6'h30; // Sits above payload byte 7 so all eight bytes are reachable.
    localparam logic [5:0] OFS_PRIORITY  = 6'h34;
    localparam logic [5:0] OFS_STAMP_HI  = 6'h38;
    localparam logic [5:0] OFS_STAMP_LO  = 6'h3C;
    // Control and status words in the upper half of the window.
    localparam logic [7:0] OFS_TX_FLAG   = 8'h40; // Empty flags, write one to clear (schedule).
    localparam logic [7:0] OFS_ABORT_REQ = 8'h44;
    localparam logic [7:0] OFS_ABORT_ACK = 8'h48;
    localparam logic [7:0] OFS_SELECT    = 8'h4C;
    localparam logic [7:0] OFS_CONTROL   = 8'h50; // Bit 0 init mode, bit 1 stamp enable.
    localparam int         CTRL_INIT_BIT = 0;
    localparam int         CTRL_TIME_BIT = 1;
    localparam int         RTR_BIT       = 4;     // Remote request bit inside identifier byte 1.
    localparam int         ID_BYTES      = 4;
    localparam int         PAYLOAD_BYTES = 8;
    localparam int         DLC_MAX       = 8;
    localparam logic [2:0] EMPTY_RESET   = 3'h7;
    localparam logic [7:0] CONTROL_RESET = 8'h01;
    // Bus serialisation: one bit time per bit clock tick.
    localparam int         BIT_TIME_NS   = 1000;
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         BIT_CYCLES    = BIT_TIME_NS / CLK_PERIOD_NS;
endpackage

// ==== sim/link_model.sv ====
// Behavioural model of the link engine that frames what the scheduler hands over.
`timescale 1ns/1ns
module link_model #(
    parameter int ERRORS = 1
) (
    // Clock and reset.
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    // Bench control and scheduler handover.
    input  wire logic enable_in,
    input  wire logic frame_start_in,
    // Link status towards the scheduler.
    output logic      bus_idle_out,
    output logic      tx_done_out,
    output logic      tx_error_out
);
    logic [7:0] cnt_r;
    logic       busy_r;
    int         frames_r;

    // Frames alternate slow and prompt, and the first ERRORS frames fail so that a retry is seen.
    always @(posedge clk_in) begin
        tx_done_out  <= 1'b0;
        tx_error_out <= 1'b0;
        if (sys_rst_in) begin
            busy_r       <= 1'b0;
            cnt_r        <= 8'h00;
            frames_r     <= 0;
            bus_idle_out <= 1'b0;
        end else if (frame_start_in) begin
            busy_r       <= 1'b1;
            bus_idle_out <= 1'b0;
            cnt_r        <= frames_r[0] ? 8'h03 : 8'h28;
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
            if (cnt_r == 8'h01 && busy_r) begin
                busy_r   <= 1'b0;
                frames_r <= frames_r + 1;
                cnt_r    <= 8'h04; // The bus stays busy for a short gap after each frame.
                if (frames_r < ERRORS) begin
                    tx_error_out <= 1'b1;
                end else begin
                    tx_done_out <= 1'b1;
                end
            end
        end else begin
            bus_idle_out <= enable_in;
        end
    end
endmodule

// ==== sim/tb_can_tx_buffer_scheduler.sv ====
// Self-checking testbench of the transmit buffer scheduler.
`timescale 1ns/1ns
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin failures++; \
    $display("unexpected at %0t: got %h want %h", $time, (act), (exp)); end end
module tb_can_tx_buffer_scheduler;
    import txbuf_pkg::*;
    logic        clk_in, sys_rst_in, avs_read_in, avs_write_in, link_en;
    logic [7:0]  avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, re;
    logic        avs_waitrequest_out, bus_idle, tx_done, tx_error, frame_start_out;
    logic [1:0]  tx_buf_out;
    logic        tx_remote_out, tx_irq_out, init_mode_out;
    logic [3:0]  tx_length_out, tx_bytes_out;
    logic [7:0]  local_priority_field [3];
    logic [7:0]  len [3];
    logic        rem [3];
    logic [7:0]  data;
    logic [10:0] fe;
    logic [31:0] rd_q [$];
    logic [10:0] fs_q [$];
    int          failures, checked, irq_cnt, b, i;

    can_tx_buffer_scheduler #(.NUM_BUF(3)) DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .bus_idle_in(bus_idle), .tx_done_in(tx_done),
        .tx_error_in(tx_error), .frame_start_out(frame_start_out), .tx_buf_out(tx_buf_out),
        .tx_remote_out(tx_remote_out), .tx_length_out(tx_length_out), .tx_bytes_out(tx_bytes_out),
        .tx_irq_out(tx_irq_out), .init_mode_out(init_mode_out));
    link_model #(.ERRORS(1)) link (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .enable_in(link_en),
        .frame_start_in(frame_start_out), .bus_idle_out(bus_idle), .tx_done_out(tx_done),
        .tx_error_out(tx_error));

    // Free-running 100 MHz clock.
    always #5 clk_in = ~clk_in;

    // Read data is judged only at the edge where the slave drops waitrequest.
    always @(posedge clk_in) begin
        if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0) begin
            re = rd_q.pop_front();
            `CHK(avs_readdata_out, re)
        end
    end

    // Each frame handover is compared with the next predicted winner.
    always @(posedge clk_in) begin
        if (frame_start_out === 1'b1) begin
            fe = (fs_q.size() == 0) ? 11'h7FF : fs_q.pop_front();
            `CHK({tx_buf_out, tx_remote_out, tx_length_out, tx_bytes_out}, fe)
        end
        if (tx_irq_out === 1'b1) begin
            irq_cnt++;
        end
    end

    // Hold the request until waitrequest is seen low; a stuck slave is cut off and counted.
    task automatic ack();
        int n;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 100);
        if (n >= 100) begin
            failures++;
            $display("unexpected at %0t: bus hang", $time);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        avs_address_in   <= a;
        avs_writedata_in <= {24'h000000, d};
        avs_write_in     <= 1'b1;
        ack();
        avs_write_in <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back({24'h000000, e});
        avs_address_in <= a;
        avs_read_in    <= 1'b1;
        ack();
        avs_read_in <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic wait_irq(input int n);
        int t;
        t = 0;
        while (irq_cnt < n && t < 5000) begin
            @(posedge clk_in);
            t++;
        end
        if (irq_cnt < n) begin
            failures++;
            $display("unexpected at %0t: release missing", $time);
        end
    endtask

    // Predicted frame order: smallest priority first, lower index on a tie, first winner twice.
    function automatic void sched();
        logic [2:0] used;
        int         w;
        used = 3'h0;
        for (int k = 0; k < 3; k++) begin
            w = -1;
            for (int j = 0; j < 3; j++) begin
                if (!used[j] && (w < 0 || local_priority_field[j] < local_priority_field[w])) w = j;
            end
            used[w] = 1'b1;
            repeat ((k == 0) ? 2 : 1) fs_q.push_back({2'(w), rem[w], len[w][3:0], rem[w] ? 4'h0 : len[w][3:0]});
        end
    endfunction

    task automatic close_out();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // The whole run needs a few hundred cycles; the limit of 20000 cycles leaves ample margin.
    initial begin
        #200000;
        failures++;
        $display("unexpected at %0t: watchdog", $time);
        close_out();
    end

    initial begin
        {clk_in, avs_read_in, avs_write_in, link_en, avs_address_in, avs_writedata_in} = '0;
        sys_rst_in = 1'b1;
        {failures, checked, irq_cnt} = '0;
        void'($urandom(67));
        repeat (16) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        `CHK(init_mode_out, 1'b1)
        rd(8'(OFS_CONTROL), 8'h01);
        rd(8'(OFS_TX_FLAG), 8'h07);
        rd(8'(OFS_ABORT_ACK), 8'h00);
        rd(8'h60, 8'h00);
        wr(8'(OFS_SELECT), 8'h01);
        wr(8'(OFS_STAMP_HI), 8'hFF);
        rd(8'(OFS_STAMP_HI), 8'h00);
        $display("test reset done");
        wr(8'(OFS_CONTROL), 8'h02);
        for (b = 0; b < 3; b++) begin
            local_priority_field[b] = 8'($urandom_range(3));
            rem[b]  = (b == 1);
            len[b]  = (b == 0) ? 8'h08 : (b == 1) ? 8'h05 : 8'($urandom_range(8));
            wr(8'(OFS_SELECT), 8'(1 << b));
            wr(8'(OFS_ID0) + 8'h04, rem[b] ? 8'h10 : 8'h00);
            wr(8'(OFS_LENGTH), len[b]);
            rd(8'(OFS_LENGTH), len[b]);
            wr(8'(OFS_PRIORITY), local_priority_field[b]);
            rd(8'(OFS_PRIORITY), local_priority_field[b]);
            for (i = 0; i < PAYLOAD_BYTES; i++) begin
                data = 8'($urandom);
                wr(8'(OFS_PAYLOAD0) + 8'(4 * i), data);
                rd(8'(OFS_PAYLOAD0) + 8'(4 * i), data);
            end
        end
        sched();
        wr(8'(OFS_TX_FLAG), 8'h07);
        `CHK(init_mode_out, 1'b0)
        link_en <= 1'b1;
        wait_irq(3);
        `CHK(32'(fs_q.size()), 32'h0)
        rd(8'(OFS_TX_FLAG), 8'h07);
        rd(8'(OFS_ABORT_ACK), 8'h00);
        $display("test schedule done");
        link_en <= 1'b0;
        repeat (2) @(posedge clk_in);
        wr(8'(OFS_SELECT), 8'h04);
        wr(8'(OFS_LENGTH), 8'h01);
        wr(8'(OFS_TX_FLAG), 8'h04);
        wr(8'(OFS_SELECT), 8'h04);
        wr(8'(OFS_PRIORITY), 8'hAA);
        rd(8'(OFS_PRIORITY), 8'h00);
        wr(8'(OFS_ABORT_REQ), 8'h04);
        wait_irq(4);
        rd(8'(OFS_ABORT_ACK), 8'h04);
        rd(8'(OFS_TX_FLAG), 8'h07);
        $display("test abort done");
        close_out();
    end
endmodule
